/* verilog/fps_regs.svh */
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define FPS_OP_WAKE   8'hab
`define FPS_OP_SLEEP  8'hb9
`define FPS_OP_WR_ENABLE    8'h06
`define FPS_OP_PAGE_PROG    8'h02
`define FPS_OP_SECTOR_ERASE 8'hd8
`define FPS_OP_BULK_ERASE   8'hc7
`define FPS_OP_STATUS_WR    8'h01

// ----------------------------------------
// frame layout, in link clock rising edges
// ----------------------------------------
`define FPS_LAST_INSTR_BIT 6'h07
`define FPS_LAST_DUMMY_BIT 6'h1f
`define FPS_LAST_SIG_BIT   6'h27
`define FPS_SIG_MSB        3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define FPS_CLK_MHZ        125
`define FPS_SHORT_REL_NS   3000
`define FPS_LONG_REL_NS    5000
`define FPS_INHIBIT_US     1000
// least times round up to whole cycles
`define FPS_SHORT_REL_CYC  ((`FPS_SHORT_REL_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_LONG_REL_CYC   ((`FPS_LONG_REL_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_INHIBIT_CYC    (`FPS_INHIBIT_US * `FPS_CLK_MHZ)

`endif

/* verilog/fps_pkg.sv */
`default_nettype none
package fps_pkg;

   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_DUMMY,
      ST_TX,
      ST_SLEEP,
      ST_IGNORE,
      ST_RELEASE
   } fps_state_t;

   // ----------------------------------------
   // whole state of the core
   // ----------------------------------------
   typedef struct packed {
      fps_state_t  fsm;
      logic [5:0]  bitCnt;
      logic [6:0]  shift;
      logic [2:0]  sigPtr;
      logic        sigDone;
      logic        deep;
      logic [9:0]  relCnt;
      logic [16:0] inhibitCnt;
      logic        inhibit;
      logic        wrLatch;
      logic        sdo;
      logic        oeN;
      logic        cmdValid;
      logic [7:0]  cmdCode;
      logic        prevClk;
      logic        prevSel;
   } fps_st_t;

endpackage
`default_nettype wire

/* verilog/fps_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstN,
   // pins and their synchronised copy
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinSync
);
   logic [WIDTH-1:0] meta_q;

   // two flops; the first is read by the second only
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_q  <= '1;
         pinSync <= '1;
      end else begin
         meta_q  <= pinIn;
         pinSync <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* verilog/fps_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fps_regs.svh"

module fps_top #(
   parameter logic [16:0] INHIBIT_CYCLES = 17'(`FPS_INHIBIT_CYC),
   parameter logic [7:0]  SIGNATURE      = 8'h5a  // arbitrary value
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // serial link pins
   input  wire logic        selN,
   input  wire logic        sclk,
   input  wire logic        sdi,
   output var  logic        sdo,
   output var  logic        sdoOeN,
   // rest of the device
   input  wire logic        busyCycle,
   input  wire logic        latchClear,
   output var  logic        deepSleep,
   output var  logic        writeInhibit,
   output var  logic        writeEnableLatch,
   output var  logic        cmdValid,
   output var  logic [7:0]  cmdCode
);
   import fps_pkg::*;

   // ----------------------------------------
   // reset release and pin sampling
   // ----------------------------------------
   logic    rstMeta_q;
   logic    rstN;
   logic    selS;
   logic    clkS;
   logic    sdiS;
   fps_st_t q;
   fps_st_t n;

   // reset asserts at once, releases through two flops
   // por hold
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstN      <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN      <= rstMeta_q;
      end
   end

   fps_sync #(.WIDTH(3)) uSync (
      .clk     (clk),
      .rstN    (rstN),
      .pinIn   ({selN, sclk, sdi}),
      .pinSync ({selS, clkS, sdiS})
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // write class codes, blocked while the supply settles
   function automatic logic isWriteClass(input logic [7:0] op);
      return (op == `FPS_OP_WR_ENABLE) || (op == `FPS_OP_PAGE_PROG) || (op == `FPS_OP_SECTOR_ERASE) ||
             (op == `FPS_OP_BULK_ERASE) || (op == `FPS_OP_STATUS_WR);
   endfunction

   logic       rise;
   logic       fall;
   logic [7:0] opByte;
   assign rise   = clkS & ~q.prevClk;
   assign fall   = ~clkS & q.prevClk;
   assign opByte = {q.shift, sdiS};

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      n          = q;
      n.cmdValid = 1'b0;
      n.prevClk  = clkS;
      n.prevSel  = selS;
      if (q.inhibitCnt != '0) begin
         n.inhibitCnt = q.inhibitCnt - 17'h00001;
      end
      n.inhibit = (n.inhibitCnt != '0);
      if (latchClear) begin
         n.wrLatch = 1'b0;
      end
      case (q.fsm)
         ST_IDLE: begin
            // only a select fall opens a frame; select held low across release starts nothing, but held low across reset it reads as a fall
            if (!selS && q.prevSel) begin
               n.fsm     = ST_CMD;
               n.bitCnt  = '0;
               n.sigDone = 1'b0;
            end
         end
         ST_CMD: begin
            if (selS) begin
               n.fsm = ST_IDLE;  // short byte, nothing happens
            end else if (rise) begin
               n.shift  = opByte[6:0];
               n.bitCnt = q.bitCnt + 6'h01;
               if (q.bitCnt == `FPS_LAST_INSTR_BIT) begin
                  n.fsm = ST_IGNORE;
                  // idle wake decoded; busy wake dropped
                  if (opByte == `FPS_OP_WAKE && !busyCycle) begin
                     n.fsm = ST_DUMMY;
                  end else if (opByte == `FPS_OP_WAKE || q.deep) begin
                     n.fsm = ST_IGNORE;
                  // only this code arms deep sleep
                  end else if (opByte == `FPS_OP_SLEEP) begin
                     n.fsm = busyCycle ? ST_IGNORE : ST_SLEEP;
                  end else if (!(isWriteClass(opByte) && q.inhibit)) begin
                     n.cmdValid = 1'b1;
                     n.cmdCode  = opByte;
                     if (opByte == `FPS_OP_WR_ENABLE) begin
                        n.wrLatch = 1'b1;
                     end
                  end
               end
            end
         end
         ST_DUMMY, ST_TX: begin
            if (selS) begin
               n.oeN = 1'b1;
               n.fsm = ST_IDLE;
               if (q.deep) begin
                  n.fsm = ST_RELEASE;
                  n.relCnt = q.sigDone ? 10'(`FPS_LONG_REL_CYC - 1) : 10'(`FPS_SHORT_REL_CYC - 1);
               end
            end else begin
               if (rise && q.bitCnt != `FPS_LAST_SIG_BIT + 6'h01) begin
                  n.bitCnt = q.bitCnt + 6'h01;
                  if (q.bitCnt == `FPS_LAST_DUMMY_BIT) begin
                     n.fsm    = ST_TX;
                     n.sigPtr = `FPS_SIG_MSB;
                  end
                  if (q.bitCnt == `FPS_LAST_SIG_BIT) begin
                     n.sigDone = 1'b1;
                  end
               end
               if (fall && q.fsm == ST_TX) begin
                  n.sdo    = SIGNATURE[q.sigPtr];
                  n.oeN    = 1'b0;
                  n.sigPtr = q.sigPtr - 3'h1;
               end
            end
         end
         ST_SLEEP: begin
            // further clocks cancel the power-down
            if (selS) begin
               n.deep = 1'b1;
               n.fsm  = ST_IDLE;
            end else if (rise) begin
               n.fsm = ST_IGNORE;
            end
         end
         ST_IGNORE: begin
            if (selS) begin
               n.fsm = ST_IDLE;
            end
         end
         ST_RELEASE: begin
            // select is not watched until the delay ends
            if (q.relCnt == '0) begin
               n.deep = 1'b0;
               n.fsm  = ST_IDLE;
            end else begin
               n.relCnt = q.relCnt - 10'h001;
            end
         end
         default: n.fsm = ST_IDLE;
      endcase
   end

   // power-up state is standby, latch clear
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         q            <= '0;
         q.fsm        <= ST_IDLE;
         q.inhibitCnt <= INHIBIT_CYCLES;
         q.inhibit    <= 1'b1;
         q.oeN        <= 1'b1;
         q.prevClk    <= 1'b1;
         q.prevSel    <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sdo              = q.sdo;
   assign sdoOeN           = q.oeN;
   assign deepSleep        = q.deep;
   assign writeInhibit     = q.inhibit;
   assign writeEnableLatch = q.wrLatch;
   assign cmdValid         = q.cmdValid;
   assign cmdCode          = q.cmdCode;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstN);

   sequence s_wakeEnd;
      (q.fsm == ST_TX || q.fsm == ST_DUMMY) && selS;
   endsequence
   sequence s_wakeByte;
      q.fsm == ST_CMD && !selS && rise && q.bitCnt == `FPS_LAST_INSTR_BIT && opByte == `FPS_OP_WAKE;
   endsequence

   a_deep_blocks_cmd: assert property (cmdValid |-> !deepSleep)
      else $error("command passed during deep sleep");
   a_wake_leaves_sleep: assert property ($fell(deepSleep) |-> $past(q.fsm) == ST_RELEASE)
      else $error("deep sleep left without release");
   a_wake_decoded: assert property (s_wakeByte ##0 !busyCycle |=> q.fsm == ST_DUMMY)
      else $error("idle wake not decoded");
   a_busy_wake_drop: assert property (s_wakeByte ##0 busyCycle |=> q.fsm == ST_IGNORE)
      else $error("wake decoded while busy");
   a_sig_msb_first: assert property (q.fsm == ST_TX && fall && q.sigPtr == `FPS_SIG_MSB && !selS
      |=> sdo == SIGNATURE[`FPS_SIG_MSB] && !sdoOeN)
      else $error("signature not msb first");
   a_awake_standby: assert property (s_wakeEnd ##0 !q.deep |=> q.fsm == ST_IDLE && sdoOeN)
      else $error("awake deselect not immediate");
   a_long_release: assert property (s_wakeEnd ##0 q.deep && q.sigDone
      |=> q.relCnt == 10'(`FPS_LONG_REL_CYC - 1))
      else $error("long release delay wrong");
   a_short_release: assert property (s_wakeEnd ##0 q.deep && !q.sigDone
      |=> q.relCnt == 10'(`FPS_SHORT_REL_CYC - 1))
      else $error("short release delay wrong");
   a_inhibit_write: assert property (cmdValid && isWriteClass(cmdCode) |-> !$past(writeInhibit))
      else $error("write class passed during inhibit");
   a_sleep_entry: assert property ($rose(deepSleep) |-> $past(q.fsm) == ST_SLEEP && $past(selS))
      else $error("deep sleep entered without instruction");
endmodule
`default_nettype wire

/* test/fps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_host_model (
   // clock
   input  wire logic        clk,
   // serial link pins
   output var  logic        selN,
   output var  logic        sclk,
   output var  logic        sdi,
   input  wire logic        sdo
);
   logic [15:0] rx;

   // idle: deselected, link clock parked low
   initial begin
      selN = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // one framed transfer of nBits clocks; sdo bits past the dummies land in rx
   task automatic xfer(input logic [7:0] code, input int nBits);
      rx = 16'h0;
      @(posedge clk);
      selN <= 1'b0;
      for (int i = 0; i < nBits; i++) begin
         // code msb first, then dummy bytes
         sdi <= (i < 8) ? code[7 - i] : i[0];
         repeat (5) @(posedge clk);
         // sample late in the low phase, after the device shifted
         if (i >= 32) rx = {rx[14:0], sdo};
         sclk <= 1'b1;
         repeat (5) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (5) @(posedge clk);
      // deselect only after the last clock
      selN <= 1'b1;
      // a released line must not look like the last bit
      sdi <= ~sdi;
      // keep deselected before any next frame
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* test/fps_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fps_regs.svh"
module fps_top_tb_top;
   localparam logic [16:0] INH     = 17'h190;
   localparam logic [7:0]  SIG     = 8'hc5;  // arbitrary value; not bit-symmetric, so bit order shows
   localparam logic [7:0]  OP_READ = 8'h03;
   logic       clk;
   logic       nrst;
   logic       selN;
   logic       sclk;
   logic       sdi;
   logic       sdo;
   logic       sdoOeN;
   logic       busyCycle;
   logic       latchClear;
   logic       deepSleep;
   logic       writeInhibit;
   logic       writeEnableLatch;
   logic       cmdValid;
   logic [7:0] cmdCode;
   int         num_errors;
   int         checks;
   int         nCmd;
   int         nOe;

   // ----------------------------------------
   // design and host
   // ----------------------------------------
   fps_top #(.INHIBIT_CYCLES(INH), .SIGNATURE(SIG)) dut (.clk(clk), .nrst(nrst), .selN(selN),
      .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOeN(sdoOeN), .busyCycle(busyCycle), .latchClear(latchClear),
      .deepSleep(deepSleep), .writeInhibit(writeInhibit), .writeEnableLatch(writeEnableLatch),
      .cmdValid(cmdValid), .cmdCode(cmdCode));
   fps_host_model host (.clk(clk), .selN(selN), .sclk(sclk), .sdi(sdi), .sdo(sdo));

   // counts accepted bytes and any output drive
   always @(posedge clk) begin
      if (cmdValid === 1'b1) nCmd++;
      if (sdoOeN === 1'b0) nOe++;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_powerup();
      chk("deep", 16'(deepSleep), 16'h0);
      chk("latch", 16'(writeEnableLatch), 16'h0);
      chk("inhibit", 16'(writeInhibit), 16'h1);
      chk("oen", 16'(sdoOeN), 16'h1);
   endtask

   task automatic t_inhibit();
      int n;
      n = nCmd;
      host.xfer(`FPS_OP_WR_ENABLE, 8);
      chk("latch early", 16'(writeEnableLatch), 16'h0);
      host.xfer(OP_READ, 8);
      chk("read code", 16'(cmdCode), 16'(OP_READ));
      chk("read count", 16'(nCmd - n), 16'h1);
      for (int k = 0; k < 600 && writeInhibit !== 1'b0; k++) @(posedge clk);
      chk("inhibit end", 16'(writeInhibit), 16'h0);
      host.xfer(`FPS_OP_WR_ENABLE, 8);
      chk("latch set", 16'(writeEnableLatch), 16'h1);
      latchClear <= 1'b1;
      @(posedge clk);
      latchClear <= 1'b0;
      repeat (3) @(posedge clk);
      chk("latch clr", 16'(writeEnableLatch), 16'h0);
   endtask

   task automatic t_wake_awake();
      int o;
      o = nOe;
      host.xfer(`FPS_OP_WAKE, 48);
      chk("sig twice", host.rx, {SIG, SIG});
      chk("deep awake", 16'(deepSleep), 16'h0);
      chk("oe driven", 16'(nOe != o), 16'h1);
      chk("oe off", 16'(sdoOeN), 16'h1);
   endtask

   task automatic t_sleep_wake();
      int n;
      host.xfer(`FPS_OP_SLEEP, 8);
      chk("deep in", 16'(deepSleep), 16'h1);
      n = nCmd;
      host.xfer(OP_READ, 8);
      host.xfer(`FPS_OP_WR_ENABLE, 8);
      chk("sleep count", 16'(nCmd - n), 16'h0);
      chk("sleep latch", 16'(writeEnableLatch), 16'h0);
      host.xfer(`FPS_OP_WAKE, 40);
      chk("sig deep", 16'(host.rx[7:0]), 16'(SIG));
      repeat (590) @(posedge clk);
      chk("long hold", 16'(deepSleep), 16'h1);
      repeat (100) @(posedge clk);
      chk("long out", 16'(deepSleep), 16'h0);
   endtask

   task automatic t_short();
      host.xfer(`FPS_OP_SLEEP, 8);
      host.xfer(`FPS_OP_WAKE, 16);
      repeat (340) @(posedge clk);
      chk("short hold", 16'(deepSleep), 16'h1);
      repeat (100) @(posedge clk);
      chk("short out", 16'(deepSleep), 16'h0);
   endtask

   task automatic t_busy();
      int o;
      busyCycle <= 1'b1;
      o = nOe;
      host.xfer(`FPS_OP_WAKE, 40);
      chk("busy oen", 16'(nOe - o), 16'h0);
      host.xfer(`FPS_OP_SLEEP, 8);
      chk("busy deep", 16'(deepSleep), 16'h0);
      busyCycle <= 1'b0;
   endtask

   // mid-run reset from deep sleep with the latch set
   task automatic t_reset();
      host.xfer(`FPS_OP_WR_ENABLE, 8);
      host.xfer(`FPS_OP_SLEEP, 8);
      chk("pre latch", 16'(writeEnableLatch), 16'h1);
      chk("pre deep", 16'(deepSleep), 16'h1);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("rst hold", 16'(deepSleep), 16'h0);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      chk("rst deep", 16'(deepSleep), 16'h0);
      chk("rst latch", 16'(writeEnableLatch), 16'h0);
      chk("rst inhibit", 16'(writeInhibit), 16'h1);
      host.xfer(`FPS_OP_WR_ENABLE, 8);
      chk("rst refuse", 16'(writeEnableLatch), 16'h0);
   endtask

   // ----------------------------------------
   // clock, main sequence, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      nrst = 1'b0;
      busyCycle = 1'b0;
      latchClear = 1'b0;
      num_errors = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      t_powerup();
      t_inhibit();
      t_wake_awake();
      t_sleep_wake();
      t_short();
      t_busy();
      t_reset();
      wrap_up();
   end

   // whole run is about 3900 cycles; allow over six times that
   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
